// ---- hdl/e13_pkg.sv ----
// Constants and types shared by the E13 multiplexer and its frame sequencer
package e13_pkg;
   // ------------------------------------------------------------------
   // Structure
   // ------------------------------------------------------------------
   localparam int          N_TRIB       = 4;
   localparam int          N_E1         = 16;
   localparam int          TRIB_W       = 2;
   localparam int          IDX_W        = 9;
   localparam int          E2_SET_LEN   = 212;
   localparam int          E3_SET_LEN   = 384;
   localparam int          BUF_DEPTH    = 2;
   // ------------------------------------------------------------------
   // Slot positions within a set and set numbers, counted from zero
   // ------------------------------------------------------------------
   localparam logic [8:0]  FAW_LEN      = 9'h00a;
   localparam logic [8:0]  ALARM_IDX    = 9'h00a;
   localparam logic [8:0]  NATIONAL_IDX = 9'h00b;
   localparam logic [8:0]  CTRL_LEN     = 9'h004;
   localparam logic [8:0]  STUFF_FIRST  = 9'h004;
   localparam logic [8:0]  STUFF_LAST   = 9'h007;
   localparam logic [1:0]  FIRST_SET    = 2'h0;
   localparam logic [1:0]  STUFF_SET    = 2'h3;
   // ------------------------------------------------------------------
   // Values
   // ------------------------------------------------------------------
   localparam logic [9:0]  FAW_PAT      = 10'h3d0;
   localparam logic [1:0]  MAJ_ONES     = 2'h2;
   localparam logic        STUFF_VAL    = 1'b1;
   localparam logic        FILL_VAL     = 1'b1;
   localparam logic [1:0]  BUF_FULL     = 2'h2;

   typedef enum logic [2:0] {
      SLOT_FAW   = 3'b000,
      SLOT_ALARM = 3'b001,
      SLOT_NAT   = 3'b010,
      SLOT_CTRL  = 3'b011,
      SLOT_STUFF = 3'b100,
      SLOT_DATA  = 3'b101
   } slot_kind_t;

   typedef enum logic {
      SYNC_HUNT = 1'b0,
      SYNC_LOCK = 1'b1
   } sync_state_t;
endpackage : e13_pkg

// ---- hdl/stage_if.sv ----
// Slot information passed from a frame sequencer to the multiplexer datapath
`timescale 1ns/10ps
`default_nettype none
interface stage_if;
   import e13_pkg::*;
   slot_kind_t  kind;
   logic [1:0]  trib;
   logic        stuffed;
   logic        ctrl_bit;
   logic        faw_bit;
   logic        synced;
   modport stage (output kind, output trib, output stuffed, output ctrl_bit,
                  output faw_bit, output synced);
   modport user  (input kind, input trib, input stuffed, input ctrl_bit,
                  input faw_bit, input synced);
endinterface : stage_if
`default_nettype wire

// ---- hdl/e13_stage.sv ----
// Frame sequencer for one E2 or E3 frame, building or dropping
`timescale 1ns/10ps
`default_nettype none
module e13_stage #(
   parameter int SET_LEN = 212,
   parameter bit DROP    = 1'b0
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     step,
   input  wire logic                     rx_bit,
   input  wire logic [e13_pkg::N_TRIB-1:0] stuff_cmd,
   stage_if.stage                        sif
);
   import e13_pkg::*;

   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(SET_LEN - 1);
   localparam sync_state_t      SYNC_RST = DROP ? SYNC_HUNT : SYNC_LOCK;

   logic [IDX_W-1:0]  idx_r,   idx_nxt;
   logic [1:0]        set_r,   set_nxt;
   logic [N_TRIB-1:0] stuff_r, stuff_nxt;
   logic [1:0]        cnt_r   [N_TRIB];
   logic [1:0]        cnt_nxt [N_TRIB];
   sync_state_t       sync_r,  sync_nxt;
   logic [8:0]        shift_r, shift_nxt;
   slot_kind_t        kind;
   logic [3:0]        faw_sel;

   // ------------------------------------------------------------------
   // Slot decode
   // ------------------------------------------------------------------
   always_comb begin
      faw_sel = 4'(FAW_LEN - idx_r - 9'h001);
      if (set_r == FIRST_SET && idx_r < FAW_LEN) begin
         kind = SLOT_FAW;
      end else if (set_r == FIRST_SET && idx_r == ALARM_IDX) begin
         kind = SLOT_ALARM;
      end else if (set_r == FIRST_SET && idx_r == NATIONAL_IDX) begin
         kind = SLOT_NAT;
      end else if (set_r != FIRST_SET && idx_r < CTRL_LEN) begin
         kind = SLOT_CTRL;
      end else if (set_r == STUFF_SET && idx_r >= STUFF_FIRST && idx_r <= STUFF_LAST) begin
         kind = SLOT_STUFF;
      end else begin
         kind = SLOT_DATA;
      end
   end

   // Headers are multiples of four long, so the low index bits name the tributary
   assign sif.kind     = kind;
   assign sif.trib     = idx_r[TRIB_W-1:0];
   assign sif.stuffed  = DROP ? (cnt_r[idx_r[TRIB_W-1:0]] >= MAJ_ONES)
                              : stuff_r[idx_r[TRIB_W-1:0]];
   assign sif.ctrl_bit = stuff_r[idx_r[TRIB_W-1:0]];
   assign sif.faw_bit  = (kind == SLOT_FAW) ? FAW_PAT[faw_sel] : 1'b0;
   assign sif.synced   = (sync_r == SYNC_LOCK);

   // ------------------------------------------------------------------
   // Position, justification and alignment
   // ------------------------------------------------------------------
   always_comb begin
      idx_nxt   = idx_r;
      set_nxt   = set_r;
      stuff_nxt = stuff_r;
      cnt_nxt   = cnt_r;
      sync_nxt  = sync_r;
      shift_nxt = shift_r;
      if (step) begin
         if (idx_r == LAST_IDX) begin
            idx_nxt = '0;
            set_nxt = set_r + 2'h1;
         end else begin
            idx_nxt = idx_r + 9'h001;
         end
         if (!DROP) begin
            // One decision per frame keeps control bits and stuff slot consistent
            if (set_r == FIRST_SET && idx_r == '0) begin
               stuff_nxt = stuff_cmd;
            end
         end else begin
            shift_nxt = {shift_r[7:0], rx_bit};
            if (kind == SLOT_CTRL && rx_bit) begin
               cnt_nxt[idx_r[TRIB_W-1:0]] = cnt_r[idx_r[TRIB_W-1:0]] + 2'h1;
            end
            case (sync_r)
               SYNC_HUNT: begin
                  if ({shift_r, rx_bit} == FAW_PAT) begin
                     sync_nxt = SYNC_LOCK;
                     idx_nxt  = FAW_LEN;
                     set_nxt  = FIRST_SET;
                  end
               end
               SYNC_LOCK: begin
                  // A single bad alignment bit drops lock; no flywheel
                  if (kind == SLOT_FAW && rx_bit != FAW_PAT[faw_sel]) begin
                     sync_nxt = SYNC_HUNT;
                  end
               end
               default: begin
                  sync_nxt = SYNC_HUNT;
               end
            endcase
         end
      end
      if (DROP && set_r == FIRST_SET) begin
         for (int t = 0; t < N_TRIB; t++) begin
            cnt_nxt[t] = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_r   <= '0;
         set_r   <= FIRST_SET;
         stuff_r <= '0;
         for (int t = 0; t < N_TRIB; t++) begin
            cnt_r[t] <= '0;
         end
         sync_r  <= SYNC_RST;
         shift_r <= '0;
      end else begin
         idx_r   <= idx_nxt;
         set_r   <= set_nxt;
         stuff_r <= stuff_nxt;
         cnt_r   <= cnt_nxt;
         sync_r  <= sync_nxt;
         shift_r <= shift_nxt;
      end
   end
endmodule : e13_stage
`default_nettype wire

// ---- hdl/e13_frame_multiplexer.sv ----
// E13 two-stage multiplexer: sixteen E1 into E3 and back
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Sixteen E1 tributaries map into one E3 through four E2 groups.
// - E1-to-E2 and E2-to-E3 stages run independently with own framing.
// - E2 frame is four 212-bit sets sent cyclically in order.
// - Set 1 opens with alignment word 1111010000, alarm bit, national bit.
// - Remaining set 1 bits interleave tributaries one bit each, tributary 1 first.
// - First four bits of sets 2 to 4 are control bits, one per tributary.
// - Bits 5 to 8 of set 4 are stuffing opportunities of tributaries 1 to 4.
// - Majority-zero control bits make the stuffing position carry tributary data.
// - Majority-one control bits make it a stuff bit, building and dropping.
// - E3 frame is four 384-bit sets sent cyclically in order.
// - E3 frame uses the same layout as the E2 frame.
module e13_frame_multiplexer (
   input  wire logic                        sys_clk,
   input  wire logic                        arst_n,
   input  wire logic [e13_pkg::N_E1-1:0]    e1_tx_bit,
   input  wire logic [e13_pkg::N_E1-1:0]    e1_tx_valid,
   output logic      [e13_pkg::N_E1-1:0]    e1_tx_ready,
   input  wire logic [e13_pkg::N_TRIB-1:0]  e2_stuff_req,
   input  wire logic [e13_pkg::N_TRIB-1:0]  e2_alarm_cfg,
   input  wire logic [e13_pkg::N_TRIB-1:0]  e2_national_cfg,
   input  wire logic                        e3_alarm_cfg,
   input  wire logic                        e3_national_cfg,
   output logic                             e3_tx_bit,
   output logic                             e3_tx_valid,
   input  wire logic                        e3_tx_ready,
   input  wire logic                        e3_rx_bit,
   input  wire logic                        e3_rx_valid,
   output logic      [e13_pkg::N_E1-1:0]    e1_rx_bit,
   output logic      [e13_pkg::N_E1-1:0]    e1_rx_valid,
   output logic      [e13_pkg::N_TRIB-1:0]  e2_rx_alarm,
   output logic      [e13_pkg::N_TRIB-1:0]  e2_rx_in_frame,
   output logic                             e3_rx_alarm,
   output logic                             e3_rx_national,
   output logic                             e3_rx_in_frame
);
   import e13_pkg::*;

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ------------------------------------------------------------------
   // Output buffer, two entries
   // ------------------------------------------------------------------
   logic       buf_mem_r [BUF_DEPTH];
   logic       buf_mem_nxt [BUF_DEPTH];
   logic       wr_ptr_r, wr_ptr_nxt;
   logic       rd_ptr_r, rd_ptr_nxt;
   logic [1:0] fill_r,   fill_nxt;
   logic       buf_in_ready;
   logic       tx_bit;
   logic       pop;

   // The framer always has a bit ready, so a free entry is the only stall
   assign buf_in_ready = (fill_r != BUF_FULL);
   assign pop          = e3_tx_valid && e3_tx_ready;
   assign e3_tx_valid  = (fill_r != 2'h0);
   assign e3_tx_bit    = buf_mem_r[rd_ptr_r];

   always_comb begin
      buf_mem_nxt = buf_mem_r;
      wr_ptr_nxt  = wr_ptr_r;
      rd_ptr_nxt  = rd_ptr_r;
      fill_nxt    = fill_r;
      if (buf_in_ready) begin
         buf_mem_nxt[wr_ptr_r] = tx_bit;
         wr_ptr_nxt            = ~wr_ptr_r;
      end
      if (pop) begin
         rd_ptr_nxt = ~rd_ptr_r;
      end
      if (buf_in_ready && !pop) begin
         fill_nxt = fill_r + 2'h1;
      end else if (!buf_in_ready && pop) begin
         fill_nxt = fill_r - 2'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         buf_mem_r[0] <= 1'b0;
         buf_mem_r[1] <= 1'b0;
         wr_ptr_r     <= 1'b0;
         rd_ptr_r     <= 1'b0;
         fill_r       <= 2'h0;
      end else begin
         buf_mem_r <= buf_mem_nxt;
         wr_ptr_r  <= wr_ptr_nxt;
         rd_ptr_r  <= rd_ptr_nxt;
         fill_r    <= fill_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Build path: E3 sequencer
   // ------------------------------------------------------------------
   stage_if          tx3 ();
   stage_if          tx2 [N_TRIB] ();
   logic [N_TRIB-1:0] e2_bit;
   logic [N_TRIB-1:0] e2_step;
   logic             tx3_takes;

   e13_stage #(.SET_LEN(E3_SET_LEN), .DROP(1'b0)) u_tx3 (
      .clk       (sys_clk),
      .rst_n     (rst_n_r),
      .step      (buf_in_ready),
      .rx_bit    (1'b0),
      .stuff_cmd (e2_stuff_req),
      .sif       (tx3)
   );

   always_comb begin
      tx3_takes = (tx3.kind == SLOT_DATA) || (tx3.kind == SLOT_STUFF && !tx3.stuffed);
      case (tx3.kind)
         SLOT_FAW:   tx_bit = tx3.faw_bit;
         SLOT_ALARM: tx_bit = e3_alarm_cfg;
         SLOT_NAT:   tx_bit = e3_national_cfg;
         SLOT_CTRL:  tx_bit = tx3.ctrl_bit;
         SLOT_STUFF: tx_bit = tx3.stuffed ? STUFF_VAL : e2_bit[tx3.trib];
         SLOT_DATA:  tx_bit = e2_bit[tx3.trib];
         default:    tx_bit = FILL_VAL;
      endcase
   end

   // ------------------------------------------------------------------
   // Build path: four E2 sequencers, each fed by four E1 inputs
   // ------------------------------------------------------------------
   for (genvar k = 0; k < N_TRIB; k++) begin : g_tx2
      localparam logic [1:0] KK = 2'(k);
      logic [N_TRIB-1:0] stuff_cmd;
      logic              takes;
      logic              e1_sel;

      assign e2_step[k] = buf_in_ready && tx3_takes && (tx3.trib == KK);

      e13_stage #(.SET_LEN(E2_SET_LEN), .DROP(1'b0)) u_tx2 (
         .clk       (sys_clk),
         .rst_n     (rst_n_r),
         .step      (e2_step[k]),
         .rx_bit    (1'b0),
         .stuff_cmd (stuff_cmd),
         .sif       (tx2[k])
      );

      // A tributary with nothing queued at frame start is justified this frame
      for (genvar t = 0; t < N_TRIB; t++) begin : g_trib
         localparam logic [1:0] TT = 2'(t);
         assign stuff_cmd[t] = ~e1_tx_valid[{KK, TT}];
         assign e1_tx_ready[{KK, TT}] = e2_step[k] && takes && (tx2[k].trib == TT)
                                        && e1_tx_valid[{KK, TT}];
      end

      always_comb begin
         takes  = (tx2[k].kind == SLOT_DATA)
                  || (tx2[k].kind == SLOT_STUFF && !tx2[k].stuffed);
         e1_sel = e1_tx_valid[{KK, tx2[k].trib}] ? e1_tx_bit[{KK, tx2[k].trib}] : FILL_VAL;
         case (tx2[k].kind)
            SLOT_FAW:   e2_bit[k] = tx2[k].faw_bit;
            SLOT_ALARM: e2_bit[k] = e2_alarm_cfg[k];
            SLOT_NAT:   e2_bit[k] = e2_national_cfg[k];
            SLOT_CTRL:  e2_bit[k] = tx2[k].ctrl_bit;
            SLOT_STUFF: e2_bit[k] = tx2[k].stuffed ? STUFF_VAL : e1_sel;
            SLOT_DATA:  e2_bit[k] = e1_sel;
            default:    e2_bit[k] = FILL_VAL;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Drop path: E3 sequencer
   // ------------------------------------------------------------------
   stage_if rx3 ();
   stage_if rx2 [N_TRIB] ();
   logic    rx3_takes;
   logic    e3_alarm_r, e3_alarm_nxt;
   logic    e3_nat_r,   e3_nat_nxt;

   e13_stage #(.SET_LEN(E3_SET_LEN), .DROP(1'b1)) u_rx3 (
      .clk       (sys_clk),
      .rst_n     (rst_n_r),
      .step      (e3_rx_valid),
      .rx_bit    (e3_rx_bit),
      .stuff_cmd ('0),
      .sif       (rx3)
   );

   assign rx3_takes = rx3.synced && ((rx3.kind == SLOT_DATA)
                      || (rx3.kind == SLOT_STUFF && !rx3.stuffed));
   assign e3_rx_alarm    = e3_alarm_r;
   assign e3_rx_national = e3_nat_r;
   assign e3_rx_in_frame = rx3.synced;

   always_comb begin
      e3_alarm_nxt = e3_alarm_r;
      e3_nat_nxt   = e3_nat_r;
      if (e3_rx_valid && rx3.synced && rx3.kind == SLOT_ALARM) begin
         e3_alarm_nxt = e3_rx_bit;
      end
      if (e3_rx_valid && rx3.synced && rx3.kind == SLOT_NAT) begin
         e3_nat_nxt = e3_rx_bit;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         e3_alarm_r <= 1'b0;
         e3_nat_r   <= 1'b0;
      end else begin
         e3_alarm_r <= e3_alarm_nxt;
         e3_nat_r   <= e3_nat_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Drop path: four E2 sequencers delivering E1 bits
   // ------------------------------------------------------------------
   for (genvar k = 0; k < N_TRIB; k++) begin : g_rx2
      localparam logic [1:0] KK = 2'(k);
      logic              step;
      logic              takes;
      logic [N_TRIB-1:0] bit_r,   bit_nxt;
      logic [N_TRIB-1:0] vld_r,   vld_nxt;
      logic              alarm_r, alarm_nxt;

      assign step = e3_rx_valid && rx3_takes && (rx3.trib == KK);

      e13_stage #(.SET_LEN(E2_SET_LEN), .DROP(1'b1)) u_rx2 (
         .clk       (sys_clk),
         .rst_n     (rst_n_r),
         .step      (step),
         .rx_bit    (e3_rx_bit),
         .stuff_cmd ('0),
         .sif       (rx2[k])
      );

      assign takes = rx2[k].synced && ((rx2[k].kind == SLOT_DATA)
                     || (rx2[k].kind == SLOT_STUFF && !rx2[k].stuffed));
      assign e1_rx_bit[4*k +: N_TRIB]   = bit_r;
      assign e1_rx_valid[4*k +: N_TRIB] = vld_r;
      assign e2_rx_alarm[k]             = alarm_r;
      assign e2_rx_in_frame[k]          = rx2[k].synced;

      always_comb begin
         bit_nxt   = bit_r;
         vld_nxt   = '0;
         alarm_nxt = alarm_r;
         if (step && takes) begin
            bit_nxt[rx2[k].trib] = e3_rx_bit;
            vld_nxt[rx2[k].trib] = 1'b1;
         end
         if (step && rx2[k].synced && rx2[k].kind == SLOT_ALARM) begin
            alarm_nxt = e3_rx_bit;
         end
      end

      always_ff @(posedge sys_clk or negedge rst_n_r) begin
         if (!rst_n_r) begin
            bit_r   <= '0;
            vld_r   <= '0;
            alarm_r <= 1'b0;
         end else begin
            bit_r   <= bit_nxt;
            vld_r   <= vld_nxt;
            alarm_r <= alarm_nxt;
         end
      end
   end
endmodule : e13_frame_multiplexer
`default_nettype wire

// ---- sim/e13_monitor.sv ----
// Checker for the E13 line output and the tributary handshakes
`timescale 1ns/10ps
`default_nettype none
module e13_monitor (
   input wire logic                      sys_clk,
   input wire logic                      arst_n,
   input wire logic [e13_pkg::N_E1-1:0]  e1_tx_valid,
   input wire logic [e13_pkg::N_E1-1:0]  e1_tx_ready,
   input wire logic                      e3_alarm_cfg,
   input wire logic                      e3_national_cfg,
   input wire logic                      e3_tx_bit,
   input wire logic                      e3_tx_valid,
   input wire logic                      e3_tx_ready,
   input wire logic                      e3_rx_valid,
   input wire logic [e13_pkg::N_E1-1:0]  e1_rx_valid,
   input wire logic                      e3_rx_in_frame
);
   import e13_pkg::*;
   // ----------
   // Position of each accepted line bit
   // ----------
   logic       take;
   logic [1:0] set_r, set_nxt;
   logic [8:0] idx_r, idx_nxt;
   logic [3:0] ctrl_r, ctrl_nxt;
   assign take = e3_tx_valid & e3_tx_ready;
   always_comb begin
      set_nxt  = set_r;
      idx_nxt  = idx_r + 9'h001;
      ctrl_nxt = ctrl_r;
      if (set_r == 2'h1 && idx_r < CTRL_LEN) begin
         ctrl_nxt[idx_r[1:0]] = e3_tx_bit;
      end
      if (idx_r == 9'(E3_SET_LEN - 1)) begin
         idx_nxt = 9'h000;
         set_nxt = set_r + 2'h1;
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         set_r  <= 2'h0;
         idx_r  <= 9'h000;
         ctrl_r <= 4'h0;
      end else if (take) begin
         set_r  <= set_nxt;
         idx_r  <= idx_nxt;
         ctrl_r <= ctrl_nxt;
      end
   end
   default clocking mon_cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   faw_word_a:
      assert property (take && set_r == FIRST_SET && idx_r < FAW_LEN
                       |-> e3_tx_bit == FAW_PAT[4'(9'h009 - idx_r)])
      else $error("alignment word bit wrong");
   alarm_bit_a:
      assert property (take && set_r == FIRST_SET && idx_r == ALARM_IDX
                       |-> e3_tx_bit == e3_alarm_cfg)
      else $error("alarm bit wrong");
   national_bit_a:
      assert property (take && set_r == FIRST_SET && idx_r == NATIONAL_IDX
                       |-> e3_tx_bit == e3_national_cfg)
      else $error("national bit wrong");
   ctrl_repeat_a:
      assert property (take && set_r >= 2'h2 && idx_r < CTRL_LEN
                       |-> e3_tx_bit == ctrl_r[idx_r[1:0]])
      else $error("control bit changed");
   stuff_slot_a:
      assert property (take && set_r == STUFF_SET && idx_r >= STUFF_FIRST
                       && idx_r <= STUFF_LAST && ctrl_r[idx_r[1:0]] |-> e3_tx_bit == STUFF_VAL)
      else $error("stuff slot carries data");
   line_hold_a:
      assert property (e3_tx_valid && !e3_tx_ready |=> e3_tx_valid && $stable(e3_tx_bit))
      else $error("line bit moved in stall");
   offer_needed_a:
      assert property ((e1_tx_ready & ~e1_tx_valid) == '0)
      else $error("take without offer");
   one_taker_a:
      assert property ($onehot0(e1_tx_ready))
      else $error("two takes at once");
   drop_single_a:
      assert property (|e1_rx_valid |-> $past(e3_rx_valid) && $onehot0(e1_rx_valid))
      else $error("drop without line bit");
   drop_locked_a:
      assert property (|e1_rx_valid |-> e3_rx_in_frame)
      else $error("drop out of frame");
endmodule : e13_monitor
bind e13_frame_multiplexer e13_monitor u_e13_monitor (.*);
`default_nettype wire

// ---- sim/e13_line_sink.sv ----
// Line partner: takes the E3 stream and loops it back to the receiver
`timescale 1ns/10ps
`default_nettype none
module e13_line_sink (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic slow,
   input  wire logic tx_bit,
   input  wire logic tx_valid,
   output var logic  tx_ready,
   output var logic  rx_bit,
   output var logic  rx_valid
);
   logic [1:0] phase;
   logic       got_q[$];
   // Slow mode refuses every third cycle so the buffer fills
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase    <= 2'h0;
         tx_ready <= 1'b0;
         rx_valid <= 1'b0;
         rx_bit   <= 1'b0;
      end else begin
         phase    <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
         tx_ready <= !slow || phase != 2'h2;
         rx_valid <= tx_valid && tx_ready;
         if (tx_valid && tx_ready) begin
            got_q.push_back(tx_bit);
            rx_bit <= tx_bit;
         end else begin
            // Idle line shows no stale bit
            rx_bit <= !rx_bit;
         end
      end
   end
endmodule : e13_line_sink
`default_nettype wire

// ---- sim/test_e13_frame_multiplexer.sv ----
// Self-checking bench for the E13 multiplexer in line loopback
`timescale 1ns/10ps
`default_nettype none
module test_e13_frame_multiplexer;
   import e13_pkg::*;
   localparam int         FRAME     = 4 * E3_SET_LEN;
   localparam int         E2_FRAME  = 4 * E2_SET_LEN;
   localparam int         TIMEOUT   = 40000;
   localparam logic [3:0] STUFF_REQ = 4'h5;
   logic        sys_clk, arst_n, slow;
   logic [15:0] e1_tx_bit, e1_tx_valid, e1_tx_ready, e1_rx_bit, e1_rx_valid;
   logic [3:0]  e2_stuff_req, e2_alarm_cfg, e2_national_cfg, e2_rx_alarm, e2_rx_in_frame;
   logic        e3_alarm_cfg, e3_national_cfg, e3_tx_bit, e3_tx_valid, e3_tx_ready;
   logic        e3_rx_bit, e3_rx_valid, e3_rx_alarm, e3_rx_national, e3_rx_in_frame;
   int          fail_count, num_checks, cycles, cnt[16];
   logic        tx_q[16][$], rx_q[16][$], e2q[4][$];
   e13_frame_multiplexer u_e13_frame_multiplexer (.*);
   e13_line_sink u_e13_line_sink (.sys_clk, .arst_n, .slow, .tx_bit(e3_tx_bit),
      .tx_valid(e3_tx_valid), .tx_ready(e3_tx_ready), .rx_bit(e3_rx_bit),
      .rx_valid(e3_rx_valid));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ----------
   // Helpers
   // ----------
   function automatic logic pat(int i, int k);
      return ^(8'(k * 5 + i * 3));
   endfunction : pat
   function automatic logic lb(int n);
      return u_e13_line_sink.got_q[n];
   endfunction : lb
   task automatic check_val(input logic [3:0] got, input logic [3:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val
   task automatic wait_bits(input int m);
      while (u_e13_line_sink.got_q.size() < m) @(posedge sys_clk);
   endtask : wait_bits
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   // Tributary sources and sinks
   always @(posedge sys_clk) begin
      cycles++;
      for (int i = 0; i < 16; i++) begin
         if (e1_tx_ready[i] === 1'b1) begin
            tx_q[i].push_back(e1_tx_bit[i]);
            cnt[i]++;
            e1_tx_bit[i] <= pat(i, cnt[i]);
         end
         if (e1_rx_valid[i] === 1'b1)
            rx_q[i].push_back(e1_rx_bit[i]);
      end
      if (cycles == TIMEOUT) begin
         fail_count++;
         report_and_stop();
      end
   end
   // ----------
   // Scenarios
   // ----------
   task automatic test_reset_start();
      int n = 0;
      check_val({3'h0, e3_tx_valid}, 4'h0);
      check_val({3'h0, |e1_tx_ready}, 4'h0);
      arst_n <= 1'b1;
      while (e3_tx_valid !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      check_val({3'h0, e3_tx_bit}, 4'h1);
      $display("reset test done");
   endtask : test_reset_start
   task automatic test_e3_layout();
      int p, x;
      wait_bits(4 * FRAME);
      for (int n = 0; n < 4 * FRAME; n++) begin
         p = n % FRAME;
         x = p % E3_SET_LEN;
         if (p < 10)
            check_val(lb(n), FAW_PAT[9 - p]);
         else if (p == 10)
            check_val(lb(n), e3_alarm_cfg);
         else if (p == 11)
            check_val(lb(n), e3_national_cfg);
         else if (p >= E3_SET_LEN && x < 4)
            check_val(lb(n), STUFF_REQ[x]);
         else if (p >= 3 * E3_SET_LEN && x < 8 && STUFF_REQ[x - 4])
            check_val(lb(n), STUFF_VAL);
      end
      $display("test e3 layout done");
   endtask : test_e3_layout
   task automatic test_e2_layout();
      int f, p, x, t;
      logic sk;
      for (int n = 0; n < 4 * FRAME; n++) begin
         f = n - n % FRAME;
         p = n % FRAME;
         x = p % E3_SET_LEN;
         t = x % 4;
         sk = int'(lb(f + E3_SET_LEN + t)) + int'(lb(f + 2 * E3_SET_LEN + t))
              + int'(lb(f + 3 * E3_SET_LEN + t)) >= 2;
         if (p >= 12 && !(p >= E3_SET_LEN && x < 4) && !(p >= 3 * E3_SET_LEN && x < 8 && sk))
            e2q[t].push_back(lb(n));
      end
      for (int g = 0; g < 4; g++) begin
         for (int k = 0; k < 10; k++) begin
            check_val(e2q[g][k], FAW_PAT[9 - k]);
            check_val(e2q[g][E2_FRAME + k], FAW_PAT[9 - k]);
         end
         check_val(e2q[g][10], e2_alarm_cfg[g]);
         check_val(e2q[g][11], e2_national_cfg[g]);
         for (t = 0; t < 4; t++) begin
            check_val(e2q[g][12 + t], (g + t == 0) ? FILL_VAL : pat(4 * g + t, 0));
            check_val(e2q[g][3 * E2_SET_LEN + t], g + t == 0);
            check_val(e2q[g][E2_FRAME + E2_SET_LEN + t], g + t == 0);
         end
      end
      check_val(e2q[0][3 * E2_SET_LEN + 4], STUFF_VAL);
      check_val(e2q[1][3 * E2_SET_LEN + 4], pat(4, 154));
      $display("test e2 layout done");
   endtask : test_e2_layout
   task automatic test_loopback();
      logic hit;
      slow <= 1'b1;
      e2_alarm_cfg <= 4'h6;
      wait_bits(12 * FRAME);
      for (int i = 0; i < 16; i++) begin
         hit = 1'b0;
         for (int o = 0; o + rx_q[i].size() <= tx_q[i].size() && !hit; o++) begin
            hit = 1'b1;
            foreach (rx_q[i][j]) hit &= rx_q[i][j] === tx_q[i][o + j];
         end
         if (i == 0) begin
            hit = 1'b1;
            foreach (rx_q[0][j]) hit &= rx_q[0][j] === FILL_VAL;
         end
         check_val({3'h0, hit && rx_q[i].size() > 8}, 4'h1);
      end
      check_val(e2_rx_alarm, 4'h6);
      check_val(e2_rx_in_frame, 4'hf);
      check_val(e3_rx_alarm, e3_alarm_cfg);
      check_val(e3_rx_national, e3_national_cfg);
      check_val(e3_rx_in_frame, 1'b1);
      $display("test loopback done");
   endtask : test_loopback
   initial begin
      slow = 1'b0;
      arst_n = 1'b0;
      e1_tx_valid = 16'hfffe;
      e2_stuff_req = STUFF_REQ;
      e2_alarm_cfg = 4'h9;
      e2_national_cfg = 4'h6;
      e3_alarm_cfg = 1'b1;
      e3_national_cfg = 1'b0;
      for (int i = 0; i < 16; i++) begin
         e1_tx_bit[i] = pat(i, 0);
      end
      repeat (8) @(posedge sys_clk);
      test_reset_start();
      test_e3_layout();
      test_e2_layout();
      test_loopback();
      report_and_stop();
   end
endmodule : test_e13_frame_multiplexer
`default_nettype wire
